/* File: gcr_control.sv */
`timescale 1ns/100ps
module gcr_control
	import gcr_pkg::*;
#(
	parameter int LOW_CYC  = REMOTE_LOW_CYC,
	parameter int HIGH_CYC = REMOTE_HIGH_CYC,
	parameter int BUS_CYC  = BUS_PERIOD_CYC,
	parameter int WDOG_TO  = WDOG_CYC,
	parameter int MODULES  = 4
) (
	input  wire logic        core_clk_i,              // System clock, 10 MHz.
	input  wire logic        rst_n_i,                 // Synchronous reset, active low.
	input  wire logic        key_gauge_one_i,         // Gauge one key press pulse.
	input  wire logic        key_gauge_two_i,         // Gauge two key press pulse.
	input  wire logic        key_outgas_i,            // Outgas key press pulse.
	input  wire logic        key_power_i,             // Power key press pulse.
	input  wire logic        remote_gauge_one_toggle_n_i, // Remote gauge one pin, low active.
	input  wire logic        remote_gauge_two_toggle_n_i, // Remote gauge two pin, low active.
	input  wire logic        remote_outgas_n_i,       // Remote outgas pin, low active.
	input  wire logic        key_inhibit_n_i,         // Front key inhibit pin, low active.
	input  wire logic        gauge_lockout_n_i,       // Gauge lockout pin, low active.
	input  wire logic        auto_on_one_i,           // Auto-on pulse for gauge one.
	input  wire logic        auto_on_two_i,           // Auto-on pulse for gauge two.
	input  wire logic        auto_off_i,              // Auto-off pulse for running gauge.
	input  wire logic        host_on_one_i,           // Computer gauge one on pulse.
	input  wire logic        host_on_two_i,           // Computer gauge two on pulse.
	input  wire logic        host_off_i,              // Computer gauges off pulse.
	input  wire logic        host_outgas_i,           // Computer outgas toggle pulse.
	input  wire logic        fault_source_jumper_i,   // High routes outgas status to fault relay.
	input  wire logic [1:0]  units_i,                 // Pressure units selection.
	input  wire logic [15:0] pressure_i,              // Gauge pressure, BCD mantissa and exponent.
	input  wire logic [MODULES-1:0] wdog_kick_i,      // Checkpoint pulses, one per module.
	input  wire logic        checksum_fail_i,         // Setpoint board checksum failure pulse.
	input  wire logic        fault_clear_i,           // Clears the latched fault.
	input  wire logic [15:0] msg_data_i,              // Word sent in the messaging slot.
	output logic             gauge_one_relay_o,       // Gauge one filament relay.
	output logic             gauge_two_relay_o,       // Gauge two filament relay.
	output logic             outgas_o,                // Outgas running.
	output logic             fault_relay_o,           // Fault relay, energized means healthy when the jumper is low.
	output logic             power_toggle_o,          // Power key toggle pulse.
	output logic [MODULES-1:0] wdog_reset_o,          // Watchdog reset pulse per module.
	output logic [15:0]      bus_data_o,              // Display bus data word.
	output logic [3:0]       bus_slot_o,              // Display bus slot number.
	output logic             bus_strobe_o,            // One-cycle bus update strobe.
	output logic             bus_msg_o,               // Current slot is messaging.
	output logic [15:0]      captured_pressure_o,     // Pressure taken from display slots.
	output logic             bargraph_mtorr_o         // Bargraph in millitorr.
);
	initial begin
		if (BUS_CYC < 1 || WDOG_TO < 1 || MODULES < 1) $error("Bad parameter value.");
	end

	logic rem_one;
	logic rem_two;
	logic rem_outgas;
	logic inh_s1;
	logic inh_s2;
	logic lock_s1;
	logic lock_s2;
	logic lock_prev;
	logic gauge_one;
	logic gauge_two;
	logic [31:0] bus_cnt;
	logic [31:0] wdog_cnt [MODULES];
	logic [MODULES-1:0] wdog_fire;
	logic fault;

	// Remote pins each pass through a filter that times low and high phases.
	gcr_remote_filter #(.LOW_CYC(LOW_CYC), .HIGH_CYC(HIGH_CYC)) u_rem_one (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.pin_n_i    (remote_gauge_one_toggle_n_i),
		.press_o    (rem_one)
	);
	gcr_remote_filter #(.LOW_CYC(LOW_CYC), .HIGH_CYC(HIGH_CYC)) u_rem_two (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.pin_n_i    (remote_gauge_two_toggle_n_i),
		.press_o    (rem_two)
	);
	gcr_remote_filter #(.LOW_CYC(LOW_CYC), .HIGH_CYC(HIGH_CYC)) u_rem_outgas (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.pin_n_i    (remote_outgas_n_i),
		.press_o    (rem_outgas)
	);

	// Level pins are synchronized; only the second stage is read.
	always_ff @(posedge core_clk_i) begin
		inh_s1  <= rst_n_i ? key_inhibit_n_i : 1'b1;
		inh_s2  <= rst_n_i ? inh_s1 : 1'b1;
		lock_s1 <= rst_n_i ? gauge_lockout_n_i : 1'b1;
		lock_s2 <= rst_n_i ? lock_s1 : 1'b1;
	end

	// Key inhibit masks front keys but leaves the power key alive.
	wire keys_ok   = inh_s2;
	wire locked    = !lock_s2;
	wire lock_edge = locked && !lock_prev;
	wire k_one     = keys_ok && key_gauge_one_i;
	wire k_two     = keys_ok && key_gauge_two_i;
	wire k_outgas  = keys_ok && key_outgas_i;

	// Toggle requests from key and remote pin, the pin acting like the key.
	wire tog_one = k_one || rem_one;
	wire tog_two = k_two || rem_two;
	// Lockout blocks turn-on from keys and computer; remote and auto-on pass.
	wire on_one  = (tog_one && !gauge_one && !(locked && k_one)) || auto_on_one_i
		|| (host_on_one_i && !locked);
	wire on_two  = (tog_two && !gauge_two && !(locked && k_two)) || auto_on_two_i
		|| (host_on_two_i && !locked);
	wire off_one = (tog_one && gauge_one) || host_off_i || auto_off_i || lock_edge;
	wire off_two = (tog_two && gauge_two) || host_off_i || auto_off_i || lock_edge;
	// Gauge one wins a simultaneous turn-on so only one runs.
	wire win_two = on_two && !on_one;
	// A fresh lockout beats any same-cycle turn-on, so the gauge never survives it.
	wire next_gauge_one = lock_edge ? 1'b0 : on_one ? 1'b1 : (win_two || off_one) ? 1'b0 : gauge_one;
	wire next_gauge_two = lock_edge ? 1'b0 : win_two ? 1'b1 : (on_one || off_two) ? 1'b0 : gauge_two;

	// Threshold check on the BCD pressure: exponent more negative, or equal and mantissa smaller.
	wire       is_pa    = (units_i == UNITS_PA);
	wire [7:0] thr_mant = is_pa ? THR_PA_MANT : THR_TORR_MANT;
	wire [6:0] thr_exp  = is_pa ? THR_PA_EXP : THR_TORR_EXP;
	wire       p_neg    = pressure_i[7];
	wire       below    = p_neg && ((pressure_i[6:0] > thr_exp)
		|| (pressure_i[6:0] == thr_exp && pressure_i[15:8] < thr_mant));
	wire tog_outgas = k_outgas || rem_outgas || host_outgas_i;
	wire running    = next_gauge_one || next_gauge_two;
	// A gauge swap also drops outgas, since the other gauge was not cleaned.
	wire swap       = (gauge_one && !next_gauge_one) || (gauge_two && !next_gauge_two);
	wire next_outgas = (!running || swap) ? 1'b0 :
		tog_outgas ? (outgas_o ? 1'b0 : below) : outgas_o;

	// Gauge state and relays; reset leaves everything off.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			gauge_one         <= 1'b0;
			gauge_two         <= 1'b0;
			outgas_o          <= 1'b0;
			lock_prev         <= 1'b0;
			gauge_one_relay_o <= 1'b0;
			gauge_two_relay_o <= 1'b0;
			power_toggle_o    <= 1'b0;
		end else begin
			gauge_one         <= next_gauge_one;
			gauge_two         <= next_gauge_two;
			outgas_o          <= next_outgas;
			lock_prev         <= locked;
			gauge_one_relay_o <= next_gauge_one;
			gauge_two_relay_o <= next_gauge_two;
			power_toggle_o    <= key_power_i;
		end
	end

	// One watchdog per module processor; a missed checkpoint fires a reset pulse.
	genvar gi;
	generate
		for (gi = 0; gi < MODULES; gi++) begin : g_wdog
			assign wdog_fire[gi] = (wdog_cnt[gi] >= 32'(WDOG_TO - 1));
			always_ff @(posedge core_clk_i) begin
				if (!rst_n_i) begin
					wdog_cnt[gi]     <= 32'h0;
					wdog_reset_o[gi] <= 1'b0;
				end else begin
					wdog_cnt[gi]     <= (wdog_kick_i[gi] || wdog_fire[gi]) ? 32'h0 : wdog_cnt[gi] + 32'h1;
					wdog_reset_o[gi] <= wdog_fire[gi] && !wdog_kick_i[gi];
				end
			end
		end
	endgenerate

	// Fault latches on a watchdog reset or checksum failure; a new event beats the clear.
	wire fault_evt  = (|(wdog_fire & ~wdog_kick_i)) || checksum_fail_i;
	wire next_fault = fault_evt ? 1'b1 : fault_clear_i ? 1'b0 : fault;
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			fault         <= 1'b0;
			fault_relay_o <= 1'b0;
		end else begin
			fault         <= next_fault;
			fault_relay_o <= fault_source_jumper_i ? next_outgas : !next_fault;
		end
	end

	// Display bus sequencer: a strobe each millisecond, slot 15 is messaging.
	wire bus_tick = (bus_cnt >= 32'(BUS_CYC - 1));
	wire [3:0] next_slot = bus_slot_o + 4'h1;
	wire next_msg = (next_slot == MSG_SLOT);
	// BCD pressure word for display slots, message word otherwise.
	wire [15:0] next_bus = next_msg ? msg_data_i : pressure_i;
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			bus_cnt             <= 32'h0;
			bus_slot_o          <= 4'hf;
			bus_strobe_o        <= 1'b0;
			bus_msg_o           <= 1'b0;
			bus_data_o          <= 16'h0;
			captured_pressure_o <= 16'h0;
			bargraph_mtorr_o    <= 1'b0;
		end else begin
			bus_cnt      <= bus_tick ? 32'h0 : bus_cnt + 32'h1;
			bus_strobe_o <= bus_tick;
			if (bus_tick) begin
				bus_slot_o <= next_slot;
				bus_msg_o  <= next_msg;
				bus_data_o <= next_bus;
				if (!next_msg) begin
					captured_pressure_o <= next_bus;
				end
			end
			bargraph_mtorr_o <= (units_i == UNITS_TORR);
		end
	end

	// Checks on the control and bus behaviour.
	sequence s_both_on;
		gauge_one_relay_o && gauge_two_relay_o;
	endsequence
	AST_EXCLUSIVE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		not s_both_on) else $error("Both gauges on.");
	AST_OUTGAS_NEEDS_GAUGE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		outgas_o |-> (gauge_one || gauge_two)) else $error("Outgas without gauge.");
	AST_OUTGAS_THRESHOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(outgas_o) |-> $past(below)) else $error("Outgas above threshold.");
	AST_LOCKOUT_OFF: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		lock_edge |=> !gauge_one_relay_o && !gauge_two_relay_o) else $error("Lockout did not stop gauge.");
	AST_LOCK_KEY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(locked && !gauge_one && k_one && !rem_one && !auto_on_one_i) |=> !gauge_one) else $error("Key passed lockout.");
	AST_INHIBIT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(!inh_s2 && !gauge_one && key_gauge_one_i && !rem_one && !auto_on_one_i && !host_on_one_i)
		|=> !gauge_one) else $error("Key passed inhibit.");
	AST_TOGGLE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(k_one && gauge_one && !on_one) |=> !gauge_one) else $error("Key did not toggle off.");
	AST_MSG_SLOT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		bus_msg_o |-> bus_slot_o == MSG_SLOT) else $error("Messaging slot misplaced.");
	AST_STROBE_SPACING: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		bus_strobe_o |=> !bus_strobe_o) else $error("Bus strobes too close.");
	AST_FAULT_RELAY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(checksum_fail_i && !fault_source_jumper_i) |=> !fault_relay_o) else $error("Fault relay held.");

	// Request steps named once, so the turn-on and outgas turn-off checks below read as request then result.
	sequence s_host_one;
		host_on_one_i && !locked;
	endsequence
	sequence s_remote_one;
		rem_one && !gauge_one && !k_one && !lock_edge;
	endsequence
	sequence s_outgas_off;
		tog_outgas && outgas_o && running && !swap;
	endsequence

	// A computer turn-on outside lockout must always land.
	AST_HOST_ON: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		s_host_one |=> gauge_one) else $error("Host request ignored.");

	// A recognized remote low turns an idle gauge on, like its key.
	AST_REMOTE_ON: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		s_remote_one |=> gauge_one) else $error("Remote request ignored.");

	// Any toggle source stops running outgas on the next edge.
	AST_OUTGAS_TOGGLE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		s_outgas_off |=> !outgas_o) else $error("Outgas did not toggle off.");

	// Computer turn-on of gauge two is refused while locked out.
	AST_LOCK_HOST: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(locked && host_on_two_i && !gauge_two && !rem_two && !auto_on_two_i) |=> !gauge_two)
		else $error("Host passed lockout.");

	// The relay follows the filament state with no extra lag.
	AST_RELAY_TWO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		gauge_two_relay_o == gauge_two) else $error("Relay disagrees with gauge.");

	// With the jumper fitted the fault relay mirrors outgas instead of faults.
	AST_JUMPER: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		fault_source_jumper_i |=> fault_relay_o == outgas_o) else $error("Jumper route wrong.");

	// Starved watchdog 0 must produce its reset pulse, and its counter never overruns.
	AST_WDOG_FIRE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(wdog_fire[0] && !wdog_kick_i[0]) |=> wdog_reset_o[0]) else $error("Watchdog silent.");
	AST_WDOG_BOUND: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wdog_cnt[0] < 32'(WDOG_TO)) else $error("Watchdog counter overran.");

	// Any monitored fault event latches the fault flag.
	AST_FAULT_LATCH: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		fault_evt |=> fault) else $error("Fault not latched.");

	// Display slots carry the pressure word; consumers pick it up on that strobe.
	AST_BUS_DATA: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(bus_tick && !next_msg) |=> bus_data_o == $past(pressure_i)) else $error("Bus data wrong.");
	AST_CAPTURE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(bus_tick && !next_msg) |=> captured_pressure_o == $past(pressure_i)) else $error("Capture missed.");

	// The messaging slot carries the message word.
	AST_MSG_DATA: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(bus_tick && next_msg) |=> bus_data_o == $past(msg_data_i)) else $error("Message word wrong.");

	// Each counter wrap strobes, and the counter stays inside one period.
	AST_BUS_TICK: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		bus_tick |=> bus_strobe_o) else $error("Bus strobe missing.");
	AST_BUS_BOUND: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		bus_cnt < 32'(BUS_CYC)) else $error("Bus counter overran.");

	// Millitorr bargraph only for torr, in both directions.
	AST_MTORR_ON: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(units_i == UNITS_TORR) |=> bargraph_mtorr_o) else $error("Bargraph not millitorr.");
	AST_MTORR_OFF: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(units_i != UNITS_TORR) |=> !bargraph_mtorr_o) else $error("Bargraph millitorr in other units.");

	// Reset is checked without the disable, since reset itself is the trigger here.
	AST_RESET_OFF: assert property (@(posedge core_clk_i)
		!rst_n_i |=> (!gauge_one && !gauge_two && !outgas_o)) else $error("Reset left a gauge on.");
endmodule

/* File: gcr_pkg.sv */
package gcr_pkg;
	// Clock rate in kHz (10 MHz core clock).
	localparam int CLK_KHZ = 10000;
	// Remote input timing in milliseconds.
	localparam int REMOTE_LOW_MS  = 25;
	localparam int REMOTE_HIGH_MS = 105;
	localparam int REMOTE_LOW_CYC  = REMOTE_LOW_MS * CLK_KHZ;
	localparam int REMOTE_HIGH_CYC = REMOTE_HIGH_MS * CLK_KHZ;
	// Display bus: one cycle per millisecond, sixteen cycles per group.
	localparam int BUS_PERIOD_MS  = 1;
	localparam int BUS_PERIOD_CYC = BUS_PERIOD_MS * CLK_KHZ;
	localparam int BUS_GROUP      = 16;
	localparam logic [3:0] MSG_SLOT = 4'hf;
	// Watchdog timeout default in cycles.
	localparam int WDOG_CYC = 100000;
	// Outgas pressure threshold as BCD mantissa digit pair and exponent.
	// Pressure word: [15:8] two BCD mantissa digits d.d, [7] exponent sign (1 = negative), [6:0] exponent.
	localparam logic [7:0] THR_TORR_MANT = 8'h50;
	localparam logic [6:0] THR_TORR_EXP  = 7'h05;
	localparam logic [7:0] THR_PA_MANT   = 8'h66;
	localparam logic [6:0] THR_PA_EXP    = 7'h03;
	// Units selection codes.
	localparam logic [1:0] UNITS_TORR = 2'h0;
	localparam logic [1:0] UNITS_MBAR = 2'h1;
	localparam logic [1:0] UNITS_PA   = 2'h2;
	// Remote filter states.
	typedef enum logic [2:0] {
		RF_IDLE = 3'b001,
		RF_LOW  = 3'b010,
		RF_HOLD = 3'b100
	} gcr_rf_state_t;
endpackage

/* File: gcr_remote_filter.sv */
`timescale 1ns/100ps
module gcr_remote_filter
	import gcr_pkg::*;
#(
	parameter int LOW_CYC  = REMOTE_LOW_CYC,
	parameter int HIGH_CYC = REMOTE_HIGH_CYC
) (
	input  wire logic core_clk_i,  // System clock.
	input  wire logic rst_n_i,     // Synchronous reset, active low.
	input  wire logic pin_n_i,     // Raw remote pin, active low.
	output logic      press_o      // One-cycle recognized request.
);
	initial begin
		if (LOW_CYC < 1 || HIGH_CYC < 1) $error("Filter counts must be positive.");
	end

	logic          sync1_n;
	logic          sync2_n;
	logic [31:0]   cnt;
	gcr_rf_state_t state;
	gcr_rf_state_t next_state;

	wire low_done  = (cnt >= 32'(LOW_CYC - 1));
	wire high_done = (cnt >= 32'(HIGH_CYC - 1));

	// Two flip-flops bring the pin into the clock domain.
	always_ff @(posedge core_clk_i) begin
		sync1_n <= rst_n_i ? pin_n_i : 1'b1;
		sync2_n <= rst_n_i ? sync1_n : 1'b1;
	end

	// A low must be held unbroken, then a full high gap before re-arming.
	always_comb begin
		next_state = state;
		case (state)
			RF_IDLE: if (!sync2_n) next_state = RF_LOW;
			RF_LOW: begin
				if (sync2_n) next_state = RF_IDLE;
				else if (low_done) next_state = RF_HOLD;
			end
			RF_HOLD: if (!sync2_n) next_state = RF_HOLD;
				else if (high_done) next_state = RF_IDLE;
			default: next_state = RF_IDLE;
		endcase
	end

	// Counter restarts on every state change and on a low during hold.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state   <= RF_IDLE;
			cnt     <= 32'h0;
			press_o <= 1'b0;
		end else begin
			state   <= next_state;
			cnt     <= (next_state != state || (state == RF_HOLD && !sync2_n)) ? 32'h0 : cnt + 32'h1;
			press_o <= (state == RF_LOW) && !sync2_n && low_done;
		end
	end

	AST_NO_EARLY_PRESS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		press_o |-> $past(state) == RF_LOW) else $error("Press without held low.");
endmodule

/* File: gcr_remote_model.sv */
`timescale 1ns/100ps
// Stand-in for the contact closures wired to the three low-active remote pins.
// Open pins sit high through the pull-up, so a released pin reads high and never holds its last value.
module gcr_remote_model (
	input  wire logic       core_clk_i, // System clock.
	input  wire logic       go_i,       // Start one closure.
	input  wire logic [1:0] sel_i,      // Pin: 0 gauge one, 1 gauge two, 2 outgas.
	input  wire logic [7:0] len_i,      // Closure length in cycles.
	output logic      [2:0] pin_n_o,    // Pins, low while closed.
	output logic            busy_o      // Closure in progress.
);
	logic [7:0] cnt;

	// Open contacts at time zero so the pins never start unknown.
	initial begin
		pin_n_o = 3'h7;
		cnt = 8'h00;
	end

	// The length is the caller's choice, so a closure shorter than the minimum can be sent on purpose.
	always @(posedge core_clk_i) begin
		if (go_i && cnt == 8'h00) begin
			pin_n_o[sel_i] <= 1'b0;
			cnt <= len_i;
		end else if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
			if (cnt == 8'h01) begin
				pin_n_o <= 3'h7;
			end
		end
	end

	// Busy drops on the same edge that opens the contact.
	assign busy_o = (cnt != 8'h00);
endmodule

/* File: gauge_control_remote_io_tb_top.sv */
`timescale 1ns/100ps
// Self-checking bench; remote pins come from the closure model, checkpoints and clock from background blocks, all other inputs from the main sequence.
module gauge_control_remote_io_tb_top;
	import gcr_pkg::*;
	// Positions of the pulse inputs in the pulse vector, and the shortened bus period.
	localparam int K1 = 0, K2 = 1, KO = 2, KP = 3, A1 = 4, A2 = 5, AO = 6, H1 = 7;
	localparam int H2 = 8, HO = 9, HG = 10, CS = 11, FC = 12, BUSC = 4;
	logic        core_clk_i;
	logic        rst_n_i = 1'b0;
	logic [12:0] pls = '0;
	logic        inh_n = 1'b1;
	logic        lock_n = 1'b1;
	logic        jmp = 1'b0;
	logic        go = 1'b0;
	logic [1:0]  units = 2'h0;
	logic [1:0]  sel = 2'h0;
	logic [7:0]  len = 8'h00;
	logic [15:0] press = 16'h4085;
	logic [15:0] msg = 16'h0c3a;
	logic [3:0]  kmask = 4'hf;
	logic [3:0]  kick = 4'h0;
	logic [2:0]  kc = 3'h0;
	logic        busy, g1, g2, og, fr, pwr, strb, bmsg, mt;
	logic [2:0]  pin_n;
	logic [3:0]  wrst, slot, pslot;
	logic [15:0] bdat, cap;
	// Outgas cases: bit 18 expected result, bits 17:16 units, bits 15:0 pressure word.
	logic [18:0] otab [8] = '{19'h06085, 19'h46086, 19'h54085, 19'h15084, 19'h26783, 19'h66583, 19'h05085, 19'h26683};
	int          fails = 0;
	int          total_checks = 0;
	int          ncyc = 0;
	int          w, i, ms;

	gcr_control #(.LOW_CYC(5), .HIGH_CYC(10), .BUS_CYC(BUSC), .WDOG_TO(20), .MODULES(4)) i_dut (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .key_gauge_one_i(pls[K1]), .key_gauge_two_i(pls[K2]),
		.key_outgas_i(pls[KO]), .key_power_i(pls[KP]), .remote_gauge_one_toggle_n_i(pin_n[0]),
		.remote_gauge_two_toggle_n_i(pin_n[1]), .remote_outgas_n_i(pin_n[2]), .key_inhibit_n_i(inh_n),
		.gauge_lockout_n_i(lock_n), .auto_on_one_i(pls[A1]), .auto_on_two_i(pls[A2]), .auto_off_i(pls[AO]),
		.host_on_one_i(pls[H1]), .host_on_two_i(pls[H2]), .host_off_i(pls[HO]), .host_outgas_i(pls[HG]),
		.fault_source_jumper_i(jmp), .units_i(units), .pressure_i(press), .wdog_kick_i(kick),
		.checksum_fail_i(pls[CS]), .fault_clear_i(pls[FC]), .msg_data_i(msg), .gauge_one_relay_o(g1),
		.gauge_two_relay_o(g2), .outgas_o(og), .fault_relay_o(fr), .power_toggle_o(pwr), .wdog_reset_o(wrst),
		.bus_data_o(bdat), .bus_slot_o(slot), .bus_strobe_o(strb), .bus_msg_o(bmsg),
		.captured_pressure_o(cap), .bargraph_mtorr_o(mt)
	);

	gcr_remote_model i_remote (.core_clk_i(core_clk_i), .go_i(go), .sel_i(sel), .len_i(len),
		.pin_n_o(pin_n), .busy_o(busy));

	// 10 MHz core clock.
	initial begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end

	// Background checkpoints every eight cycles; clearing a bit in kmask starves that watchdog.
	always @(negedge core_clk_i) begin
		kc <= kc + 3'h1;
		kick <= (kc == 3'h0) ? kmask : 4'h0;
	end

	// Hang guard: the whole run needs about five hundred cycles.
	always @(posedge core_clk_i) begin
		ncyc <= ncyc + 1;
		if (ncyc == 20000) begin
			fails = fails + 1;
			end_sim();
		end
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chkb(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask

	// One-cycle pulse; the answer is already visible when the task returns.
	task automatic pulse(input int b);
		@(negedge core_clk_i);
		pls[b] = 1'b1;
		@(negedge core_clk_i);
		pls = '0;
	endtask

	// One closure through the model, then a short pause so the filter's answer has landed.
	task automatic closure(input logic [1:0] s, input logic [7:0] n);
		int n_w;
		n_w = 0;
		@(negedge core_clk_i);
		go = 1'b1;
		sel = s;
		len = n;
		@(negedge core_clk_i);
		go = 1'b0;
		while (busy && n_w < 300) begin
			@(negedge core_clk_i);
			n_w++;
		end
		cyc(4);
	endtask

	task automatic rel(input logic e1, input logic e2, input logic eo);
		chkb("gauge one relay", e1, g1);
		chkb("gauge two relay", e2, g2);
		chkb("outgas", eo, og);
	endtask

	task automatic tdone(input string name);
		$display("test %s finished, %0d mismatches so far", name, fails);
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Main sequence: each group below is one test.
	initial begin
		cyc(10);
		rel(1'b0, 1'b0, 1'b0);
		chkb("fault relay in reset", 1'b0, fr);
		rst_n_i = 1'b1;
		cyc(3);
		chkb("fault relay healthy", 1'b1, fr);
		tdone("reset");
		pulse(K1);
		rel(1'b1, 1'b0, 1'b0);
		pulse(H2);
		rel(1'b0, 1'b1, 1'b0);
		pulse(A1);
		rel(1'b1, 1'b0, 1'b0);
		pulse(A2);
		rel(1'b0, 1'b1, 1'b0);
		pulse(AO);
		rel(1'b0, 1'b0, 1'b0);
		pulse(H1);
		pulse(K1);
		rel(1'b0, 1'b0, 1'b0);
		pulse(K2);
		pulse(HO);
		rel(1'b0, 1'b0, 1'b0);
		tdone("sources");
		inh_n = 1'b0;
		cyc(5);
		pulse(K1);
		rel(1'b0, 1'b0, 1'b0);
		pulse(KP);
		chkb("power toggle", 1'b1, pwr);
		pulse(H1);
		inh_n = 1'b1;
		cyc(5);
		pulse(K1);
		rel(1'b0, 1'b0, 1'b0);
		tdone("inhibit");
		pulse(H1);
		lock_n = 1'b0;
		cyc(5);
		rel(1'b0, 1'b0, 1'b0);
		pulse(K1);
		pulse(H2);
		rel(1'b0, 1'b0, 1'b0);
		lock_n = 1'b1;
		cyc(5);
		pulse(K2);
		rel(1'b0, 1'b1, 1'b0);
		pulse(HO);
		tdone("lockout");
		pulse(KO);
		rel(1'b0, 1'b0, 1'b0);
		pulse(H1);
		for (i = 0; i < 8; i++) begin
			units = otab[i][17:16];
			press = otab[i][15:0];
			cyc(2);
			pulse(KO);
			chkb("outgas request", otab[i][18], og);
			if (otab[i][18]) begin
				pulse(KO);
			end
			chkb("outgas released", 1'b0, og);
		end
		units = UNITS_TORR;
		press = 16'h4085;
		cyc(2);
		closure(2'h2, 8'h0c);
		rel(1'b1, 1'b0, 1'b1);
		jmp = 1'b1;
		cyc(2);
		chkb("fault relay shows outgas", 1'b1, fr);
		pulse(HG);
		cyc(2);
		chkb("fault relay shows outgas", 1'b0, fr);
		jmp = 1'b0;
		pulse(HG);
		chkb("outgas by host", 1'b1, og);
		pulse(K2);
		rel(1'b0, 1'b1, 1'b0);
		pulse(KO);
		rst_n_i = 1'b0;
		cyc(4);
		rel(1'b0, 1'b0, 1'b0);
		rst_n_i = 1'b1;
		cyc(3);
		tdone("outgas");
		closure(2'h0, 8'h0c);
		rel(1'b1, 1'b0, 1'b0);
		closure(2'h0, 8'h0c);
		rel(1'b1, 1'b0, 1'b0);
		cyc(20);
		closure(2'h0, 8'h03);
		rel(1'b1, 1'b0, 1'b0);
		cyc(20);
		closure(2'h0, 8'h0c);
		rel(1'b0, 1'b0, 1'b0);
		closure(2'h1, 8'h0c);
		rel(1'b0, 1'b1, 1'b0);
		pulse(HO);
		tdone("remote");
		kmask = 4'hb;
		w = 0;
		while (wrst[2] !== 1'b1 && w < 60) begin
			@(negedge core_clk_i);
			w++;
		end
		chkb("watchdog reset", 1'b1, wrst[2]);
		chkb("watchdog patience", 1'b1, w >= 12);
		kmask = 4'hf;
		cyc(2);
		chkb("fault relay on watchdog", 1'b0, fr);
		pulse(FC);
		cyc(2);
		chkb("fault relay cleared", 1'b1, fr);
		pulse(CS);
		cyc(2);
		chkb("fault relay on checksum", 1'b0, fr);
		pulse(FC);
		tdone("fault");
		w = 0;
		while (strb !== 1'b1 && w < 10) begin
			@(negedge core_clk_i);
			w++;
		end
		pslot = slot - 4'h1;
		ms = 0;
		for (i = 0; i < 32; i++) begin
			chk("bus data", (slot == 4'hf) ? msg : press, bdat);
			chkb("bus message flag", slot == 4'hf, bmsg);
			chk("bus slot", {12'h000, pslot + 4'h1}, {12'h000, slot});
			ms = ms + ((bmsg === 1'b1) ? 1 : 0);
			pslot = slot;
			w = 0;
			do begin
				@(negedge core_clk_i);
				w++;
			end while (strb !== 1'b1 && w < 10);
			chk("bus period", 16'(BUSC), 16'(w));
		end
		chk("captured pressure", press, cap);
		chk("message slots", 16'h0002, 16'(ms));
		for (i = 0; i < 3; i++) begin
			units = 2'(i);
			cyc(3);
			chkb("millitorr bargraph", i == 0, mt);
		end
		tdone("bus");
		end_sim();
	end
endmodule
